/* File: hdl/upc_pin_ctrl.sv */
`timescale 1ns/10ps
module upc_pin_ctrl
  import upc_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic HOST_SEL_I2C,
  input wire logic [NUM_SRC-1:0] SRC_EVENT,
  input wire logic RX_ROOM_OK,
  output logic RTS_N,
  output logic IRQ_N_O,
  output logic IRQ_N_OE,
  output logic HOST_IS_I2C,
  input wire logic [NUM_GPIO-1:0] GPIO_I,
  output logic [NUM_GPIO-1:0] GPIO_O,
  output logic [NUM_GPIO-1:0] GPIO_OE
);
  // ****************************************************************
  // Register state
  // ****************************************************************
  logic [7:0] ien_reg;
  logic [7:0] ien_next;
  logic [7:0] hs_reg;
  logic [7:0] hs_next;
  logic [7:0] feat_reg;
  logic [7:0] feat_next;
  logic [7:0] iof_reg;
  logic [7:0] iof_next;
  logic [7:0] dir_reg;
  logic [7:0] dir_next;
  logic [7:0] gout_reg;
  logic [7:0] gout_next;
  logic [NUM_SRC-1:0] stat_reg;
  logic [NUM_SRC-1:0] stat_next;
  logic [NUM_GPIO-1:0] gin_reg;
  logic [NUM_GPIO-1:0] gin_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic ready_reg;
  logic ready_next;
  logic err_reg;
  logic err_next;
  logic rts_n_reg;
  logic rts_n_next;
  logic irq_oe_reg;
  logic irq_oe_next;
  logic host_reg;
  logic host_next;
  logic [NUM_GPIO-1:0] go_reg;
  logic [NUM_GPIO-1:0] go_next;
  logic [NUM_GPIO-1:0] goe_reg;
  logic [NUM_GPIO-1:0] goe_next;
  logic setup;
  logic wr;
  logic hit;
  logic [NUM_SRC-1:0] clr;
  logic [NUM_SRC-1:0] ev;
  logic modem_mode;

  assign setup = PSEL && !PENABLE;
  // A write lands only at the access edge where the ready pulse is seen by the master.
  assign wr = PSEL && PENABLE && ready_reg && PWRITE;
  assign modem_mode = iof_reg[IOF_MODEM_BIT];

  always_comb begin
    ien_next = ien_reg;
    hs_next = hs_reg;
    feat_next = feat_reg;
    iof_next = iof_reg;
    dir_next = dir_reg;
    gout_next = gout_reg;
    clr = '0;
    rdata_next = rdata_reg;
    hit = 1'b1;
    unique case (PADDR)
      OFS_INT_ENABLE: rdata_next = {24'h000000, ien_reg};
      OFS_HANDSHAKE: rdata_next = {24'h000000, hs_reg};
      OFS_FEATURE: rdata_next = {24'h000000, feat_reg};
      OFS_IO_FUNC: rdata_next = {24'h000000, iof_reg};
      OFS_INT_STATUS: rdata_next = {27'h0000000, stat_reg};
      OFS_INT_CLEAR: rdata_next = 32'h00000000;
      OFS_GPIO_DIR: rdata_next = {24'h000000, dir_reg};
      OFS_GPIO_OUT: rdata_next = {24'h000000, gout_reg};
      OFS_GPIO_IN: rdata_next = {24'h000000, gin_reg};
      OFS_PIN_STATUS: rdata_next = {29'h00000000, host_reg, rts_n_reg, irq_oe_reg};
      default: begin
        rdata_next = 32'h00000000;
        hit = 1'b0;
      end
    endcase
    if (wr) begin
      unique case (PADDR)
        OFS_INT_ENABLE: ien_next = PWDATA[7:0];
        OFS_HANDSHAKE: hs_next = PWDATA[7:0];
        OFS_FEATURE: feat_next = PWDATA[7:0];
        OFS_IO_FUNC: iof_next = PWDATA[7:0];
        OFS_INT_CLEAR: clr = PWDATA[NUM_SRC-1:0];
        OFS_GPIO_DIR: dir_next = PWDATA[7:0];
        OFS_GPIO_OUT: gout_next = PWDATA[7:0];
        default: ;
      endcase
    end
    if (!setup) begin
      rdata_next = rdata_reg;
      hit = 1'b1;
    end
    ready_next = setup;
    err_next = setup && !hit;
  end

  // ****************************************************************
  // Interrupt sources and pins
  // ****************************************************************
  always_comb begin
    ev = SRC_EVENT;
    ev[SRC_PIN_CHANGE] = SRC_EVENT[SRC_PIN_CHANGE] || ((gin_reg ^ GPIO_I) != 8'h00);
    stat_next = (stat_reg & ~clr) | ev;
    irq_oe_next = (stat_next & ien_next[NUM_SRC-1:0]) != '0;
    if (feat_next[FEAT_AUTO_RTS_BIT]) begin
      rts_n_next = !RX_ROOM_OK;
    end else begin
      rts_n_next = !hs_next[HS_RTS_BIT];
    end
    gin_next = GPIO_I;
    host_next = HOST_SEL_I2C;
    go_next = gout_next;
    goe_next = dir_next;
    if (iof_next[IOF_MODEM_BIT]) begin
      goe_next[NUM_GPIO-1:MODEM_LO] = 4'h2;
      go_next[NUM_GPIO-1:MODEM_LO] = 4'h0;
      go_next[GPIO_DTR] = !hs_next[HS_DTR_BIT];
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      ien_reg <= RESET_BYTE;
      hs_reg <= RESET_BYTE;
      feat_reg <= RESET_BYTE;
      iof_reg <= RESET_BYTE;
      dir_reg <= RESET_BYTE;
      gout_reg <= RESET_BYTE;
      stat_reg <= '0;
      gin_reg <= 8'hFF;
      rdata_reg <= 32'h00000000;
      ready_reg <= 1'b0;
      err_reg <= 1'b0;
      rts_n_reg <= 1'b1;
      irq_oe_reg <= 1'b0;
      host_reg <= 1'b0;
      go_reg <= 8'h00;
      goe_reg <= 8'h00;
    end else begin
      ien_reg <= ien_next;
      hs_reg <= hs_next;
      feat_reg <= feat_next;
      iof_reg <= iof_next;
      dir_reg <= dir_next;
      gout_reg <= gout_next;
      stat_reg <= stat_next;
      gin_reg <= gin_next;
      rdata_reg <= rdata_next;
      ready_reg <= ready_next;
      err_reg <= err_next;
      rts_n_reg <= rts_n_next;
      irq_oe_reg <= irq_oe_next;
      host_reg <= host_next;
      go_reg <= go_next;
      goe_reg <= goe_next;
    end
  end

  assign PRDATA = rdata_reg;
  assign PREADY = ready_reg;
  assign PSLVERR = err_reg;
  assign RTS_N = rts_n_reg;
  // The pin only ever pulls low; the board pull-up gives the high level.
  assign IRQ_N_O = 1'b0;
  assign IRQ_N_OE = irq_oe_reg;
  assign HOST_IS_I2C = host_reg;
  assign GPIO_O = go_reg;
  assign GPIO_OE = goe_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_irq_enabled_only: assert property (@(posedge CLK) disable iff (RST)
    IRQ_N_OE |-> ($past(stat_next & ien_next[NUM_SRC-1:0]) != '0))
    else $error("irq asserted with no enabled source");
  chk_irq_release: assert property (@(posedge CLK) disable iff (RST)
    ((stat_reg & ien_reg[NUM_SRC-1:0]) == '0) |-> !IRQ_N_OE)
    else $error("irq not released");
  chk_src_sticky: assert property (@(posedge CLK) disable iff (RST)
    $past(SRC_EVENT[SRC_RX_DATA]) |-> stat_reg[SRC_RX_DATA])
    else $error("event lost");
  chk_rts_manual: assert property (@(posedge CLK) disable iff (RST)
    !feat_reg[FEAT_AUTO_RTS_BIT] |-> (RTS_N == !hs_reg[HS_RTS_BIT]))
    else $error("rts does not follow handshake bit");
  chk_rts_auto: assert property (@(posedge CLK) disable iff (RST)
    feat_reg[FEAT_AUTO_RTS_BIT] |-> (RTS_N == !$past(RX_ROOM_OK)))
    else $error("auto rts wrong");
  chk_rts_reset: assert property (@(posedge CLK)
    $fell(RST) |-> RTS_N)
    else $error("rts not high after reset");
  chk_rts_meaning: assert property (@(posedge CLK) disable iff (RST)
    (!RTS_N && !feat_reg[FEAT_AUTO_RTS_BIT]) |-> hs_reg[HS_RTS_BIT])
    else $error("rts low without data ready");
  chk_modem_pins: assert property (@(posedge CLK) disable iff (RST)
    modem_mode |-> (GPIO_OE[NUM_GPIO-1:MODEM_LO] == 4'h2))
    else $error("modem pin directions wrong");
  chk_apb_ready: assert property (@(posedge CLK) disable iff (RST)
    (PSEL && !PENABLE) |=> PREADY)
    else $error("apb ready late");
  // ****************************************************************
  // Further checks
  // ****************************************************************
  chk_rx_error_sticky: assert property (@(posedge CLK) disable iff (RST)
    SRC_EVENT[SRC_RX_ERROR] |=> stat_reg[SRC_RX_ERROR])
    else $error("rx error event lost");
  chk_tx_space_sticky: assert property (@(posedge CLK) disable iff (RST)
    SRC_EVENT[SRC_TX_SPACE] |=> stat_reg[SRC_TX_SPACE])
    else $error("tx space event lost");
  chk_modem_flag_sticky: assert property (@(posedge CLK) disable iff (RST)
    SRC_EVENT[SRC_MODEM] |=> stat_reg[SRC_MODEM])
    else $error("modem flag event lost");
  chk_pin_event_sticky: assert property (@(posedge CLK) disable iff (RST)
    SRC_EVENT[SRC_PIN_CHANGE] |=> stat_reg[SRC_PIN_CHANGE])
    else $error("pin change event lost");
  chk_gpio_change_src: assert property (@(posedge CLK) disable iff (RST)
    (gin_reg != GPIO_I) |=> stat_reg[SRC_PIN_CHANGE])
    else $error("gpio change not flagged");
  chk_clear_works: assert property (@(posedge CLK) disable iff (RST)
    (clr[SRC_RX_DATA] && !ev[SRC_RX_DATA]) |=> !stat_reg[SRC_RX_DATA])
    else $error("status clear ignored");
  chk_set_wins: assert property (@(posedge CLK) disable iff (RST)
    (ev[SRC_RX_DATA] && clr[SRC_RX_DATA]) |=> stat_reg[SRC_RX_DATA])
    else $error("clear beat a new event");
  chk_irq_on: assert property (@(posedge CLK) disable iff (RST)
    ((stat_next & ien_next[NUM_SRC-1:0]) != '0) |=> IRQ_N_OE)
    else $error("irq not asserted");
  chk_irq_drive_low: assert property (@(posedge CLK) disable iff (RST)
    IRQ_N_OE |-> !IRQ_N_O)
    else $error("irq pin driven high");
  chk_enable_write: assert property (@(posedge CLK) disable iff (RST)
    (wr && (PADDR == OFS_INT_ENABLE)) |=> (ien_reg == $past(PWDATA[7:0])))
    else $error("enable write lost");
  chk_rts_auto_room: assert property (@(posedge CLK) disable iff (RST)
    (feat_next[FEAT_AUTO_RTS_BIT] && RX_ROOM_OK) |=> !RTS_N)
    else $error("auto rts not active with room");
  chk_rts_auto_full: assert property (@(posedge CLK) disable iff (RST)
    (feat_next[FEAT_AUTO_RTS_BIT] && !RX_ROOM_OK) |=> RTS_N)
    else $error("auto rts active without room");
  chk_rts_write_low: assert property (@(posedge CLK) disable iff (RST)
    (wr && (PADDR == OFS_HANDSHAKE) && PWDATA[HS_RTS_BIT] && !feat_reg[FEAT_AUTO_RTS_BIT])
    |=> !RTS_N)
    else $error("rts write one not low");
  chk_rts_write_high: assert property (@(posedge CLK) disable iff (RST)
    (wr && (PADDR == OFS_HANDSHAKE) && !PWDATA[HS_RTS_BIT] && !feat_reg[FEAT_AUTO_RTS_BIT])
    |=> RTS_N)
    else $error("rts write zero not high");
  chk_dtr_pin: assert property (@(posedge CLK) disable iff (RST)
    modem_mode |-> (GPIO_O[GPIO_DTR] == !hs_reg[HS_DTR_BIT]))
    else $error("dtr pin level wrong");
  chk_modem_inputs_off: assert property (@(posedge CLK) disable iff (RST)
    modem_mode |-> ((GPIO_O[NUM_GPIO-1:MODEM_LO] & 4'hD) == 4'h0))
    else $error("modem input pins driven");
  chk_gpio_plain_oe: assert property (@(posedge CLK) disable iff (RST)
    !modem_mode |-> (GPIO_OE == dir_reg))
    else $error("gpio direction wrong");
  chk_gpio_plain_out: assert property (@(posedge CLK) disable iff (RST)
    !modem_mode |-> (GPIO_O == gout_reg))
    else $error("gpio output wrong");
  chk_host_copy: assert property (@(posedge CLK) disable iff (RST)
    !$past(RST) |-> (HOST_IS_I2C == $past(HOST_SEL_I2C)))
    else $error("host select copy wrong");
  chk_apb_one_cycle: assert property (@(posedge CLK) disable iff (RST)
    PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  chk_err_with_ready: assert property (@(posedge CLK) disable iff (RST)
    PSLVERR |-> PREADY)
    else $error("error without ready");
  chk_ready_after_setup: assert property (@(posedge CLK) disable iff (RST)
    PREADY |-> $past(PSEL && !PENABLE))
    else $error("ready without setup");
  chk_rdata_hold: assert property (@(posedge CLK) disable iff (RST)
    !$past(setup) |-> $stable(PRDATA))
    else $error("read data moved");
  chk_unmapped_read: assert property (@(posedge CLK) disable iff (RST)
    (setup && !hit) |=> (PRDATA == 32'h00000000))
    else $error("unmapped read not zero");
  chk_rts_reset_hold: assert property (@(posedge CLK)
    RST |=> RTS_N)
    else $error("rts low in reset");
  chk_gpio_reset_off: assert property (@(posedge CLK)
    RST |=> (GPIO_OE == 8'h00))
    else $error("gpio driven in reset");
  chk_irq_reset_off: assert property (@(posedge CLK)
    RST |=> !IRQ_N_OE)
    else $error("irq active in reset");
endmodule : upc_pin_ctrl

/* File: hdl/upc_pkg.sv */
package upc_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] OFS_INT_ENABLE = 8'h00;
  localparam logic [7:0] OFS_HANDSHAKE = 8'h04;
  localparam logic [7:0] OFS_FEATURE = 8'h08;
  localparam logic [7:0] OFS_IO_FUNC = 8'h0C;
  localparam logic [7:0] OFS_INT_STATUS = 8'h10;
  localparam logic [7:0] OFS_INT_CLEAR = 8'h14;
  localparam logic [7:0] OFS_GPIO_DIR = 8'h18;
  localparam logic [7:0] OFS_GPIO_OUT = 8'h1C;
  localparam logic [7:0] OFS_GPIO_IN = 8'h20;
  localparam logic [7:0] OFS_PIN_STATUS = 8'h24;
  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int NUM_SRC = 5;
  localparam int SRC_PIN_CHANGE = 0;
  localparam int SRC_RX_ERROR = 1;
  localparam int SRC_RX_DATA = 2;
  localparam int SRC_TX_SPACE = 3;
  localparam int SRC_MODEM = 4;
  localparam int HS_DTR_BIT = 0;
  localparam int HS_RTS_BIT = 1;
  localparam int FEAT_AUTO_RTS_BIT = 6;
  localparam int IOF_MODEM_BIT = 1;
  localparam int NUM_GPIO = 8;
  localparam int MODEM_LO = 4;
  localparam int GPIO_DTR = 5;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  typedef struct packed {
    logic dsr;
    logic cd;
    logic ri;
  } upc_modem_in_t;
endpackage : upc_pkg

/* File: dv/upc_far_model.sv */
`timescale 1ns/10ps
module upc_far_model
  import upc_pkg::*;
(
  input wire logic irq_n_o,
  input wire logic irq_n_oe,
  input wire logic [NUM_GPIO-1:0] gpio_o,
  input wire logic [NUM_GPIO-1:0] gpio_oe,
  output logic irq_wire,
  output logic [NUM_GPIO-1:0] gpio_i
);
  // ****************************************************************
  // Wire resolution
  // ****************************************************************
  // Both lines carry pull-ups, so a released line reads one, never a held value.
  assign irq_wire = irq_n_oe ? irq_n_o : 1'b1;
  always_comb begin
    for (int k = 0; k < NUM_GPIO; k++) begin
      gpio_i[k] = gpio_oe[k] ? gpio_o[k] : 1'b1;
    end
  end
endmodule : upc_far_model

/* File: dv/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  import upc_pkg::*;
  logic CLK, RST, PSEL, PENABLE, PWRITE, HOST_SEL_I2C, RX_ROOM_OK;
  logic PREADY, PSLVERR, RTS_N, IRQ_N_O, IRQ_N_OE, HOST_IS_I2C, irq_wire, err;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic [NUM_SRC-1:0] SRC_EVENT;
  logic [NUM_GPIO-1:0] GPIO_I, GPIO_O, GPIO_OE;
  int bad_count, samples_checked;
  upc_pin_ctrl DUT (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .HOST_SEL_I2C(HOST_SEL_I2C), .SRC_EVENT(SRC_EVENT), .RX_ROOM_OK(RX_ROOM_OK),
    .RTS_N(RTS_N), .IRQ_N_O(IRQ_N_O), .IRQ_N_OE(IRQ_N_OE), .HOST_IS_I2C(HOST_IS_I2C),
    .GPIO_I(GPIO_I), .GPIO_O(GPIO_O), .GPIO_OE(GPIO_OE));
  upc_far_model far (.irq_n_o(IRQ_N_O), .irq_n_oe(IRQ_N_OE), .gpio_o(GPIO_O),
    .gpio_oe(GPIO_OE), .irq_wire(irq_wire), .gpio_i(GPIO_I));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end
  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    samples_checked++;
    if (got !== ex) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb
  task settle(input int n);
    repeat (n) @(posedge CLK);
    @(negedge CLK);
  endtask : settle
  task pulse(input int i);
    @(posedge CLK);
    SRC_EVENT <= NUM_SRC'(1) << i;
    @(posedge CLK);
    SRC_EVENT <= '0;
  endtask : pulse
  task end_of_test;
    $display("mismatches %0d comparisons %0d", bad_count, samples_checked);
    if (bad_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    repeat (3000) @(posedge CLK);
    bad_count++;
    end_of_test();
  end
  initial begin
    {PSEL, PENABLE, PWRITE, RX_ROOM_OK, PADDR, PWDATA, SRC_EVENT} = '0;
    HOST_SEL_I2C = 1'b1;
    RST = 1'b1;
    bad_count = 0;
    samples_checked = 0;
    repeat (12) @(posedge CLK);
    RST <= 1'b0;
    settle(1);
    chk("rts reset", 32'h1, {31'h0, RTS_N});
    chk("irq reset", 32'h1, {31'h0, irq_wire});
    chk("host sel", 32'h1, {31'h0, HOST_IS_I2C});
    apb(1'b1, OFS_HANDSHAKE, 32'h2);
    settle(1);
    chk("rts manual", 32'h0, {31'h0, RTS_N});
    apb(1'b1, OFS_FEATURE, 32'h40);
    settle(1);
    chk("rts auto full", 32'h1, {31'h0, RTS_N});
    @(posedge CLK) RX_ROOM_OK <= 1'b1;
    settle(2);
    chk("rts auto room", 32'h0, {31'h0, RTS_N});
    apb(1'b1, OFS_FEATURE, 32'h0);
    apb(1'b1, OFS_HANDSHAKE, 32'h0);
    settle(1);
    chk("rts off", 32'h1, {31'h0, RTS_N});
    for (int i = 0; i < NUM_SRC; i++) begin
      pulse(i);
      settle(1);
      chk("irq masked", 32'h1, {31'h0, irq_wire});
      apb(1'b0, OFS_INT_STATUS, 32'h0);
      chk("status", 32'h1 << i, rd);
      apb(1'b1, OFS_INT_ENABLE, 32'h1 << i);
      settle(1);
      chk("irq on", 32'h0, {31'h0, irq_wire});
      apb(1'b1, OFS_INT_CLEAR, 32'h1 << i);
      settle(1);
      chk("irq off", 32'h1, {31'h0, irq_wire});
      apb(1'b1, OFS_INT_ENABLE, 32'h0);
    end
    apb(1'b0, 8'h3C, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    apb(1'b1, OFS_HANDSHAKE, 32'h1);
    apb(1'b1, OFS_GPIO_DIR, 32'hFF);
    apb(1'b1, OFS_IO_FUNC, 32'h2);
    settle(1);
    chk("modem oe", 32'h2F, {24'h0, GPIO_OE});
    chk("dtr level", 32'h0, {31'h0, GPIO_O[GPIO_DTR]});
    apb(1'b1, OFS_IO_FUNC, 32'h0);
    settle(1);
    chk("gpio oe", 32'hFF, {24'h0, GPIO_OE});
    end_of_test();
  end
endmodule : tb_top
